// [design/fsr_pkg.sv]
/*
 * fsr_pkg: shared constants for the self-access control block and its
 * CPU-side partner. Assumes a single 50 MHz clock for both ends.
 */
package fsr_pkg;
	// ============================================================
	// clock and timing
	localparam int FSR_CLK_HZ = 50_000_000;
	localparam int FSR_PROG_MIN_US = 3700;
	localparam int FSR_PROG_MAX_US = 4500;
	// least time, rounded up
	localparam int FSR_PROG_CYCLES = (FSR_PROG_MIN_US * (FSR_CLK_HZ / 1_000_000) + 0);
	localparam logic [2:0] FSR_LPM_WIN = 3'h3;
	localparam logic [2:0] FSR_SPM_WIN = 3'h4;
	// ============================================================
	// control register bit positions
	localparam int FSR_B_EN = 0;
	localparam int FSR_B_ERASE = 1;
	localparam int FSR_B_WRITE = 2;
	localparam int FSR_B_LOCK = 3;
	localparam int FSR_B_REEN = 4;
	localparam int FSR_B_SIG = 5;
	localparam int FSR_B_RWWB = 6;
	localparam int FSR_B_IE = 7;
	localparam logic [7:0] FSR_CTL_RESET = 8'h00;
	// ============================================================
	// configuration read addresses (Z pointer)
	localparam logic [15:0] FSR_Z_FUSE_LOW = 16'h0000;
	localparam logic [15:0] FSR_Z_LOCK = 16'h0001;
	localparam logic [15:0] FSR_Z_FUSE_EXT = 16'h0002;
	localparam logic [15:0] FSR_Z_FUSE_HIGH = 16'h0003;
	localparam logic [15:0] FSR_Z_SIG1 = 16'h0000;
	localparam logic [15:0] FSR_Z_CAL = 16'h0001;
	localparam logic [15:0] FSR_Z_SIG2 = 16'h0002;
	localparam logic [15:0] FSR_Z_SIG3 = 16'h0004;
	localparam logic [7:0] FSR_RESERVED_READ = 8'hFF;
	localparam logic [11:0] FSR_NO_READ_WHILE_WRITE_SECTION_START = 12'hC00;
	// ============================================================
	// host command port offsets
	localparam logic [2:0] FSR_H_CTL = 3'h0;
	localparam logic [2:0] FSR_H_ZLO = 3'h1;
	localparam logic [2:0] FSR_H_ZHI = 3'h2;
	localparam logic [2:0] FSR_H_DATA = 3'h3;
	localparam logic [2:0] FSR_H_GO = 3'h4;
	localparam logic [2:0] FSR_H_STAT = 3'h5;
	localparam logic [2:0] FSR_H_RES = 3'h6;
	localparam int FSR_GO_LPM = 0;
	localparam int FSR_GO_WRONLY = 1;
endpackage : fsr_pkg

// [design/fsr_if.sv]
/*
 * fsr_if: link between the CPU core end and the self-access control end.
 * Both ends share one clock; the testbench instantiates and joins them.
 */
`timescale 1ns/1ps
`default_nettype none
interface fsr_if;
	logic ctl_wr;
	logic ctl_rd;
	logic [7:0] ctl_wdata;
	logic [7:0] ctl_rdata;
	logic lpm;
	logic spm;
	logic [15:0] z;
	logic [7:0] r0;
	logic [7:0] lpm_data;
	logic lpm_valid;
	logic ee_busy;
	logic irq;
	modport dev (
		input ctl_wr, ctl_rd, ctl_wdata, lpm, spm, z, r0,
		output ctl_rdata, lpm_data, lpm_valid, ee_busy, irq
	);
	modport cpu (
		output ctl_wr, ctl_rd, ctl_wdata, lpm, spm, z, r0,
		input ctl_rdata, lpm_data, lpm_valid, ee_busy, irq
	);
endinterface : fsr_if
`default_nettype wire

// [design/fsr_dev.sv]
/*
 * fsr_dev: self-programming control register, timed configuration read
 * window, flash write timer and read-while-write busy tracking.
 * Assumes fuse, lock, signature and flash data come from same-clock logic.
 */
// Notes on behaviour
// - eeprom write busy refuses flash programming
// - eeprom write busy refuses fuse/lock reads
// - software checks eeprom busy before write
// - Z 0x0001 lock read within three cycles
// - lock/enable bits self-clear after read/timeout
// - unarmed load is ordinary flash read
// - Z 0x0000 returns fuse low byte
// - Z 0x0003 returns fuse high byte
// - Z 0x0002 returns extended fuse, low nibble
// - programmed bits read zero, unprogrammed one
// - signature mode returns row byte by Z
// - signature bits self-clear after read/timeout
// - software uses only defined signature addresses
// - core reset never aborts running flash write
// - flash writes busy between 3.7ms and 4.5ms
// - fetches only from no-rww section
// - software waits enable clear, masks interrupts
// - interrupt held while enable bit clear
// - busy flag cleared only by re-enable
`timescale 1ns/1ps
`default_nettype none
module fsr_dev
	import fsr_pkg::*;
#(
	parameter int PROG_CYCLES = FSR_PROG_CYCLES,
	parameter logic [11:0] NO_READ_WHILE_WRITE_SECTION_START = FSR_NO_READ_WHILE_WRITE_SECTION_START
) (
	// clock and power-on reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// core reset request, same clock
	input wire logic core_rst,
	// link to the cpu core
	fsr_if.dev link,
	// eeprom and nonvolatile contents, 1 = programmed
	input wire logic eeprom_write_busy_flag,
	input wire logic [7:0] fuse_low_prog,
	input wire logic [7:0] fuse_high_prog,
	input wire logic [3:0] fuse_ext_prog,
	input wire logic [5:0] lock_prog,
	input wire logic [7:0] sig_byte1,
	input wire logic [7:0] sig_byte2,
	input wire logic [7:0] sig_byte3,
	input wire logic [7:0] osc_cal_byte,
	// flash array side
	output logic [15:0] flash_addr,
	input wire logic [7:0] flash_rdata,
	input wire logic [11:0] fetch_addr,
	output logic fetch_allow,
	output logic prog_start,
	output logic [2:0] prog_kind,
	output logic [15:0] prog_addr,
	output logic [7:0] prog_data,
	output logic prog_busy
);
	localparam int CW = $clog2(PROG_CYCLES + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(PROG_CYCLES);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	// ============================================================
	// state
	logic [7:0] ctl;
	logic [2:0] win;
	logic op_busy;
	logic op_rww;
	logic [CW-1:0] op_cnt;
	logic [7:0] rd_data;
	logic rd_valid;
	logic [7:0] ctl_rd_q;
	logic st_q;
	logic [2:0] kind_q;
	logic [15:0] addr_q;
	logic [7:0] data_q;
	logic [7:0] next_ctl;
	logic [2:0] next_win;
	logic next_op_busy;
	logic next_op_rww;
	logic [CW-1:0] next_op_cnt;
	logic [7:0] next_rd_data;
	logic next_rd_valid;
	logic [7:0] next_ctl_rd_q;
	logic next_st_q;
	logic [2:0] next_kind_q;
	logic [15:0] next_addr_q;
	logic [7:0] next_data_q;

	logic armed;
	logic read_mode;
	logic [7:0] cfg_byte;

	assign armed = ctl[FSR_B_EN] && (win != 3'h0);
	assign read_mode = ctl[FSR_B_LOCK] || ctl[FSR_B_SIG];

	// ============================================================
	// configuration byte select
	always_comb begin
		cfg_byte = FSR_RESERVED_READ;
		if (ctl[FSR_B_SIG]) begin
			unique case (link.z)
				FSR_Z_SIG1: cfg_byte = sig_byte1;
				FSR_Z_CAL: cfg_byte = osc_cal_byte;
				FSR_Z_SIG2: cfg_byte = sig_byte2;
				FSR_Z_SIG3: cfg_byte = sig_byte3;
				// reserved addresses read all ones
				default: cfg_byte = FSR_RESERVED_READ;
			endcase
		end else begin
			unique case (link.z)
				FSR_Z_FUSE_LOW: cfg_byte = ~fuse_low_prog;
				FSR_Z_LOCK: cfg_byte = {2'h3, ~lock_prog};
				FSR_Z_FUSE_EXT: cfg_byte = {4'hF, ~fuse_ext_prog};
				FSR_Z_FUSE_HIGH: cfg_byte = ~fuse_high_prog;
				default: cfg_byte = FSR_RESERVED_READ;
			endcase
		end
	end

	// ============================================================
	// next state
	always_comb begin
		next_ctl = ctl;
		next_win = win;
		next_op_busy = op_busy;
		next_op_rww = op_rww;
		next_op_cnt = op_cnt;
		next_rd_data = rd_data;
		next_rd_valid = 1'b0;
		next_ctl_rd_q = ctl_rd_q;
		next_st_q = 1'b0;
		next_kind_q = kind_q;
		next_addr_q = addr_q;
		next_data_q = data_q;

		// window runs from the cycle after the write
		if (win != 3'h0) begin
			next_win = win + 3'h1;
		end
		// timeout, no store within four cycles
		if (armed && win == FSR_SPM_WIN && !link.spm) begin
			next_win = 3'h0;
			next_ctl = ctl & 8'h80 | ctl & 8'h40;
		end
		// signature mode times out after three
		if (armed && ctl[FSR_B_SIG] && win == FSR_LPM_WIN && !link.lpm) begin
			next_win = 3'h0;
			next_ctl = ctl & 8'hC0;
		end

		if (link.ctl_wr && !op_busy) begin
			next_ctl[FSR_B_IE] = link.ctl_wdata[FSR_B_IE];
			// eeprom write in progress refuses arming
			if (!(eeprom_write_busy_flag && link.ctl_wdata[FSR_B_EN])) begin
				next_ctl[5:0] = link.ctl_wdata[5:0];
				next_win = link.ctl_wdata[FSR_B_EN] ? 3'h1 : 3'h0;
			end
		end

		if (link.lpm) begin
			next_rd_valid = 1'b1;
			if (armed && read_mode && win <= FSR_LPM_WIN && !eeprom_write_busy_flag) begin
				next_rd_data = cfg_byte;
				// bits clear once the read completes
				next_ctl = ctl & 8'hC0;
				next_win = 3'h0;
			end else begin
				next_rd_data = flash_rdata;
			end
		end

		if (link.spm && armed && !op_busy) begin
			next_win = 3'h0;
			next_addr_q = link.z;
			next_data_q = link.r0;
			next_kind_q = ctl[3:1];
			next_st_q = 1'b1;
			if (ctl[FSR_B_ERASE] || ctl[FSR_B_WRITE] || ctl[FSR_B_LOCK]) begin
				// timed flash write, enable stays set
				next_op_busy = 1'b1;
				next_op_cnt = CNT_LOAD;
				next_op_rww = ctl[FSR_B_ERASE] || ctl[FSR_B_WRITE];
				if (ctl[FSR_B_ERASE] || ctl[FSR_B_WRITE]) begin
					next_ctl[FSR_B_RWWB] = 1'b1;
				end
			end else begin
				if (ctl[FSR_B_REEN]) begin
					next_ctl[FSR_B_RWWB] = 1'b0;
				end
				next_ctl = next_ctl & 8'hC0;
			end
		end

		if (op_busy) begin
			next_op_cnt = op_cnt - CNT_ONE;
			if (op_cnt == CNT_ONE) begin
				next_op_busy = 1'b0;
				next_op_rww = 1'b0;
				next_ctl = ctl & 8'hC0;
			end
		end

		if (link.ctl_rd) begin
			next_ctl_rd_q = ctl;
		end

		// core reset spares the running write
		if (core_rst) begin
			next_win = 3'h0;
			next_rd_valid = 1'b0;
			next_st_q = 1'b0;
			// keyed to the next timer state so a write ending here cannot leave enable stuck
			next_ctl = next_op_busy ? (next_ctl & 8'h4F) : (next_ctl & 8'h40);
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctl <= FSR_CTL_RESET;
			win <= 3'h0;
			op_busy <= 1'b0;
			op_rww <= 1'b0;
			op_cnt <= '0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			ctl_rd_q <= 8'h00;
			st_q <= 1'b0;
			kind_q <= 3'h0;
			addr_q <= 16'h0000;
			data_q <= 8'h00;
		end else begin
			ctl <= next_ctl;
			win <= next_win;
			op_busy <= next_op_busy;
			op_rww <= next_op_rww;
			op_cnt <= next_op_cnt;
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
			ctl_rd_q <= next_ctl_rd_q;
			st_q <= next_st_q;
			kind_q <= next_kind_q;
			addr_q <= next_addr_q;
			data_q <= next_data_q;
		end
	end

	// ============================================================
	// outputs
	assign link.ctl_rdata = ctl_rd_q;
	assign link.lpm_data = rd_data;
	assign link.lpm_valid = rd_valid;
	assign link.ee_busy = eeprom_write_busy_flag;
	// level request while enable is clear
	assign link.irq = ctl[FSR_B_IE] && !ctl[FSR_B_EN];
	assign flash_addr = link.z;
	// erase/write lets only no-rww fetches through
	assign fetch_allow = !op_rww || (fetch_addr >= NO_READ_WHILE_WRITE_SECTION_START);
	assign prog_start = st_q;
	assign prog_kind = kind_q;
	assign prog_addr = addr_q;
	assign prog_data = data_q;
	assign prog_busy = op_busy;
endmodule : fsr_dev
`default_nettype wire

// [design/fsr_cpu.sv]
/*
 * fsr_cpu: CPU-core end issuing the timed control write followed by a
 * load or store. Software drives it over a plain register port.
 * Assumes the device end shares ref_clk and reset_n.
 */
`timescale 1ns/1ps
`default_nettype none
module fsr_cpu
	import fsr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// software register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// link to the device
	fsr_if.cpu link
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_POLL = 3'b001,
		H_CHECK = 3'b010,
		H_WRITE = 3'b011,
		H_ACT = 3'b100,
		H_WAITD = 3'b101
	} fsr_hst_type;

	// ============================================================
	// state
	fsr_hst_type st;
	fsr_hst_type next_st;
	logic [7:0] ctl_val;
	logic [15:0] z;
	logic [7:0] r0;
	logic [1:0] go;
	logic [7:0] result;
	logic res_valid;
	logic [7:0] rdata_q;
	logic [7:0] next_ctl_val;
	logic [15:0] next_z;
	logic [7:0] next_r0;
	logic [1:0] next_go;
	logic [7:0] next_result;
	logic next_res_valid;
	logic [7:0] next_rdata_q;

	always_comb begin
		next_st = st;
		next_ctl_val = ctl_val;
		next_z = z;
		next_r0 = r0;
		next_go = go;
		next_result = result;
		next_res_valid = res_valid;
		next_rdata_q = rdata_q;
		if (wr && st == H_IDLE) begin
			unique case (addr)
				FSR_H_CTL: next_ctl_val = wdata;
				FSR_H_ZLO: next_z[7:0] = wdata;
				FSR_H_ZHI: next_z[15:8] = wdata;
				FSR_H_DATA: next_r0 = wdata;
				FSR_H_GO: begin
					next_go = wdata[1:0];
					next_res_valid = 1'b0;
					next_st = H_POLL;
				end
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				FSR_H_CTL: next_rdata_q = ctl_val;
				FSR_H_ZLO: next_rdata_q = z[7:0];
				FSR_H_ZHI: next_rdata_q = z[15:8];
				FSR_H_DATA: next_rdata_q = r0;
				FSR_H_STAT: next_rdata_q = {5'h00, link.irq, res_valid, st != H_IDLE};
				FSR_H_RES: next_rdata_q = result;
				default: next_rdata_q = 8'h00;
			endcase
		end
		unique case (st)
			H_IDLE: ;
			H_POLL: next_st = H_CHECK;
			H_CHECK: next_st = (link.ctl_rdata[FSR_B_EN] || link.ee_busy) ? H_POLL : H_WRITE;
			H_WRITE: next_st = go[FSR_GO_WRONLY] ? H_IDLE : H_ACT;
			H_ACT: next_st = go[FSR_GO_LPM] ? H_WAITD : H_IDLE;
			H_WAITD: begin
				next_result = link.lpm_data;
				next_res_valid = 1'b1;
				next_st = H_IDLE;
			end
			default: next_st = H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= H_IDLE;
			ctl_val <= 8'h00;
			z <= 16'h0000;
			r0 <= 8'h00;
			go <= 2'h0;
			result <= 8'h00;
			res_valid <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			st <= next_st;
			ctl_val <= next_ctl_val;
			z <= next_z;
			r0 <= next_r0;
			go <= next_go;
			result <= next_result;
			res_valid <= next_res_valid;
			rdata_q <= next_rdata_q;
		end
	end

	// ============================================================
	// link drive; the load or store follows the write back to back
	assign link.ctl_rd = (st == H_POLL);
	assign link.ctl_wr = (st == H_WRITE);
	assign link.ctl_wdata = ctl_val;
	// load right after the arming write
	assign link.lpm = (st == H_ACT) && go[FSR_GO_LPM];
	assign link.spm = (st == H_ACT) && !go[FSR_GO_LPM];
	assign link.z = z;
	assign link.r0 = r0;
	assign rdata = rdata_q;
endmodule : fsr_cpu
`default_nettype wire

// [testbench/fsr_chk_sva.sv]
/* fsr_chk_sva: assertions on the link between cpu and device ends.
   Assumes the bench instantiates it beside the joining interface. */
`timescale 1ns/1ps
`default_nettype none
module fsr_chk
	import fsr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// link signals
	input wire logic ctl_wr,
	input wire logic ctl_rd,
	input wire logic [7:0] ctl_wdata,
	input wire logic lpm,
	input wire logic spm,
	input wire logic [15:0] z,
	input wire logic [7:0] lpm_data,
	input wire logic lpm_valid,
	input wire logic ee_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ============================================================
	// armed config read: write, load, answer
	sequence cfg_rd(logic [15:0] a);
		ctl_wr && ctl_wdata == 8'h09 && !ee_busy ##1 lpm && z == a && !ee_busy ##1 lpm_valid;
	endsequence
	valid_timing_a: assert property (lpm_valid == $past(lpm))
		else $error("load answer not one cycle after load");
	data_hold_a: assert property (!lpm |=> $stable(lpm_data))
		else $error("load data moved without a load");
	one_instr_a: assert property (!(lpm && spm))
		else $error("load and store together");
	instr_follow_a: assert property (ctl_wr && ctl_wdata[FSR_B_EN] |=> lpm || spm)
		else $error("no instruction right after armed write");
	poll_first_a: assert property (ctl_wr |-> $past(ctl_rd, 2))
		else $error("control write without prior poll");
	ee_clear_a: assert property (ctl_wr |-> !$past(ee_busy))
		else $error("control write while eeprom busy");
	lock_pad_a: assert property (cfg_rd(FSR_Z_LOCK) |-> lpm_data[7:6] == 2'b11)
		else $error("lock byte upper bits not one");
	ext_pad_a: assert property (cfg_rd(FSR_Z_FUSE_EXT) |-> lpm_data[7:4] == 4'hF)
		else $error("extended fuse upper bits not one");
endmodule : fsr_chk
`default_nettype wire

// [testbench/tb_fsr.sv]
/* tb_fsr: cpu end and device end joined, driven over the software port.
   Assumes a 50 MHz clock and a short flash timer. */
`timescale 1ns/1ps
`default_nettype none
module tb_fsr;
	import fsr_pkg::*;
	localparam int PC = 20;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic core_rst = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic chk = 1'b0;
	logic chk_d = 1'b0;
	logic ee = 1'b0;
	logic [7:0] fl, fh, s1, s2, s3, cal, rdata, flash_rdata;
	logic [3:0] fe;
	logic [5:0] lk;
	logic [15:0] flash_addr, zr;
	logic [11:0] fetch_addr = 12'h000;
	logic fetch_allow, prog_busy;
	logic [7:0] exp_q[$];
	logic [31:0] len_q[$];
	logic [31:0] busy_len = 32'h0;
	logic [7:0] cmd[3] = '{8'h03, 8'h05, 8'h89};
	int error_cnt = 0;
	int num_checks = 0;
	always #10 ref_clk = ~ref_clk;
	// flash array stand-in, pattern keyed to address
	assign flash_rdata = flash_addr[7:0] ^ 8'h5A;
	fsr_if link();
	fsr_dev #(.PROG_CYCLES(PC)) fsr_dev_i (.ref_clk(ref_clk), .reset_n(reset_n), .core_rst(core_rst),
		.link(link), .eeprom_write_busy_flag(ee), .fuse_low_prog(fl), .fuse_high_prog(fh),
		.fuse_ext_prog(fe), .lock_prog(lk), .sig_byte1(s1), .sig_byte2(s2), .sig_byte3(s3),
		.osc_cal_byte(cal), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
		.fetch_addr(fetch_addr), .fetch_allow(fetch_allow), .prog_start(), .prog_kind(),
		.prog_addr(), .prog_data(), .prog_busy(prog_busy));
	fsr_cpu fsr_cpu_i (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .link(link));
	fsr_chk fsr_chk_i (.ref_clk(ref_clk), .reset_n(reset_n), .ctl_wr(link.ctl_wr),
		.ctl_rd(link.ctl_rd), .ctl_wdata(link.ctl_wdata), .lpm(link.lpm), .spm(link.spm),
		.z(link.z), .lpm_data(link.lpm_data), .lpm_valid(link.lpm_valid), .ee_busy(link.ee_busy));
	// ============================================================
	// compares and closing
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk_byte
	task automatic chk_num(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_num
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	// ============================================================
	// software port and operations
	task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w, input logic c);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		chk <= c;
		@(posedge ref_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		chk <= 1'b0;
	endtask : bus
	task automatic op(input logic [7:0] ctl, input logic [15:0] zp, input logic ld, input logic [7:0] e);
		logic [7:0] st;
		int n;
		bus(FSR_H_ZLO, zp[7:0], 1'b1, 1'b0);
		bus(FSR_H_ZHI, zp[15:8], 1'b1, 1'b0);
		bus(FSR_H_CTL, ctl, 1'b1, 1'b0);
		bus(FSR_H_GO, {7'h00, ld}, 1'b1, 1'b0);
		n = 0;
		do begin
			bus(FSR_H_STAT, 8'h00, 1'b0, 1'b0);
			#1 st = rdata;
			n++;
		end while (st[0] !== 1'b0 && n < 200);
		if (n >= 200) begin
			error_cnt++;
			end_sim();
		end
		if (ld) begin
			exp_q.push_back(e);
			bus(FSR_H_RES, 8'h00, 1'b0, 1'b1);
		end
	endtask : op
	// waits for the flash timer, optionally resets the core mid-way
	task automatic mid(input logic rst, input logic blk);
		int n;
		n = 0;
		while (prog_busy !== 1'b1 && n < 60) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= 60) begin
			error_cnt++;
			end_sim();
		end
		repeat (4) @(posedge ref_clk);
		core_rst <= rst;
		@(posedge ref_clk);
		core_rst <= 1'b0;
		#1 chk_num("fetch allow", 32'(!blk), 32'(fetch_allow));
		fetch_addr <= FSR_NO_READ_WHILE_WRITE_SECTION_START;
		@(posedge ref_clk);
		#1 chk_num("fetch no-rww", 32'h1, 32'(fetch_allow));
		fetch_addr <= FSR_NO_READ_WHILE_WRITE_SECTION_START - 12'h001;
	endtask : mid
	// raises eeprom busy k edges after the poll read of the next operation
	task automatic ee_at(input int k);
		int n;
		n = 0;
		while (link.ctl_rd !== 1'b1 && n < 60) begin
			@(posedge ref_clk);
			#1 n++;
		end
		if (n >= 60) begin
			error_cnt++;
			end_sim();
		end
		repeat (k) @(posedge ref_clk);
		ee <= 1'b1;
	endtask : ee_at
	// ============================================================
	// result watchers
	always @(posedge ref_clk) begin
		chk_d <= chk;
		if (chk_d)
			chk_byte("load result", exp_q.pop_front(), rdata);
	end
	always @(posedge ref_clk) begin
		if (prog_busy === 1'b1)
			busy_len <= busy_len + 32'h1;
		else if (busy_len != 32'h0) begin
			chk_num("busy cycles", len_q.pop_front(), busy_len);
			busy_len <= 32'h0;
		end
	end
	initial begin
		void'($urandom(32'h92E04E05));
		{fl, fh, fe, lk} = 26'($urandom);
		{s1, s2, s3, cal} = $urandom;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		op(8'h09, FSR_Z_FUSE_LOW, 1'b1, ~fl);
		op(8'h09, FSR_Z_LOCK, 1'b1, {2'b11, ~lk});
		op(8'h09, FSR_Z_FUSE_EXT, 1'b1, {4'hF, ~fe});
		op(8'h09, FSR_Z_FUSE_HIGH, 1'b1, ~fh);
		op(8'h21, FSR_Z_SIG1, 1'b1, s1);
		op(8'h21, FSR_Z_CAL, 1'b1, cal);
		op(8'h21, FSR_Z_SIG2, 1'b1, s2);
		op(8'h21, FSR_Z_SIG3, 1'b1, s3);
		op(8'h21, 16'h0003, 1'b1, FSR_RESERVED_READ);
		zr = 16'($urandom);
		op(8'h00, zr, 1'b1, zr[7:0] ^ 8'h5A);
		// eeprom busy must hold the cpu off until it clears
		ee <= 1'b1;
		fork
			op(8'h09, FSR_Z_LOCK, 1'b1, {2'b11, ~lk});
			begin
				repeat (40) @(posedge ref_clk);
				ee <= 1'b0;
			end
		join
		// busy rises after the check: arming write refused, load reads flash
		fork
			op(8'h09, FSR_Z_LOCK, 1'b1, FSR_Z_LOCK[7:0] ^ 8'h5A);
			ee_at(2);
		join
		ee <= 1'b0;
		// busy rises after the arming write: the load itself is refused
		fork
			op(8'h09, FSR_Z_LOCK, 1'b1, FSR_Z_LOCK[7:0] ^ 8'h5A);
			ee_at(3);
		join
		ee <= 1'b0;
		foreach (cmd[i]) begin
			len_q.push_back(PC);
			fetch_addr <= FSR_NO_READ_WHILE_WRITE_SECTION_START - 12'h001;
			fork
				op(cmd[i], 16'h0040, 1'b0, 8'h00);
				mid(i == 0, i < 2);
			join
			repeat (PC + 8) @(posedge ref_clk);
			chk_num("spm irq", 32'(i == 2), 32'(link.irq));
			op(8'h11, 16'h0000, 1'b0, 8'h00);
			chk_num("section busy held", 32'(i < 2), 32'(link.ctl_rdata[FSR_B_RWWB]));
			#1 chk_num("fetch after reenable", 32'h1, 32'(fetch_allow));
			op(8'h00, 16'h0000, 1'b0, 8'h00);
			chk_num("section busy cleared", 32'h0, 32'(link.ctl_rdata[FSR_B_RWWB]));
		end
		repeat (8) @(posedge ref_clk);
		chk_num("pending", 32'h0, 32'(exp_q.size() + len_q.size()));
		end_sim();
	end
endmodule : tb_fsr
`default_nettype wire
